// File: adc_encoder_pkg.sv
package adc_encoder_pkg;

    // width of the comparator thermometer pattern
    localparam int unsigned THERM_WIDTH = 15;
    // width of the converted output word
    localparam int unsigned WORD_WIDTH = 4;

    // field positions inside the output word
    localparam int unsigned MSB_POS = 3;
    localparam int unsigned LSB_FIELD_HI = 2;

    // code produced when no comparator is asserted
    localparam logic [WORD_WIDTH-1:0] FULL_SCALE_CODE = 4'hf;

    // values after reset
    localparam logic [WORD_WIDTH-1:0]  WORD_RESET   = 4'h0;
    localparam logic [THERM_WIDTH-1:0] THERM_RESET  = 15'h0000;
    localparam logic                   CTRL_RESET   = 1'h1;

    // clock figures
    localparam int unsigned CLOCK_PERIOD_PS = 10000;
    // minimum hold of the previous word after a strobe edge, in ps
    localparam int unsigned OUTPUT_HOLD_TIME_PS = 10000;
    localparam int unsigned OUTPUT_HOLD_CYCLES =
        (OUTPUT_HOLD_TIME_PS + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
    // pin synchroniser depth and the cycles from strobe pin edge to new word
    localparam int unsigned SYNC_STAGES = 2;
    localparam int unsigned OUTPUT_VALID_DELAY_CYCLES = SYNC_STAGES + 1;

endpackage : adc_encoder_pkg

// File: thermometer_encoder.sv
`timescale 1ns/1ps
`default_nettype none

module thermometer_encoder
    import adc_encoder_pkg::*;
(
    input  wire logic [THERM_WIDTH-1:0] i_therm,
    input  wire logic                   i_msb_invert_n,
    input  wire logic                   i_lsb_invert_n,
    output logic      [WORD_WIDTH-1:0]  o_code
);

    function automatic logic [WORD_WIDTH-1:0] count_ones(input logic [THERM_WIDTH-1:0] pattern);
        logic [WORD_WIDTH-1:0] total;
        total = '0;
        for (int i = 0; i < THERM_WIDTH; i++)
        begin
            total = total + {3'h0, pattern[i]};
        end
        return total;
    endfunction : count_ones

    wire logic [WORD_WIDTH-1:0] asserted_count;
    wire logic [WORD_WIDTH-1:0] true_code;

    // bubble tolerant: count ones rather than find the edge
    assign asserted_count = count_ones(i_therm);
    // all off gives full scale, all on gives zero; saturation is inherent
    assign true_code = FULL_SCALE_CODE - asserted_count;

    // low control complements its field; msb low gives offset two's complement
    assign o_code[MSB_POS] = true_code[MSB_POS] ^ ~i_msb_invert_n;
    assign o_code[LSB_FIELD_HI:0] = true_code[LSB_FIELD_HI:0] ^ {3{~i_lsb_invert_n}};

endmodule : thermometer_encoder

`default_nettype wire

// File: flash_adc_encoder_output.sv
// Notes on behaviour
// - comparators below input asserted, above deasserted
// - encode thermometer to binary or offset, invertible
// - output register holds between strobe updates
// - format controls are static active-low levels
// - msb control bit one, lsb control rest
// - control low complements its bits
// - true binary: top gives 0000, bottom 1111
// - offset true is binary with msb complemented
// - sample latched on convert strobe rising edge
// - result reaches output on next strobe edge
// - old word held, new word after delay
// - in-range input yields code zero to fifteen
// - out-of-range input saturates, above to 0000, below to 1111
`timescale 1ns/1ps
`default_nettype none

module flash_adc_encoder_output
    import adc_encoder_pkg::*;
(
    input  wire logic                   i_clock,
    input  wire logic                   i_rst_b,
    input  wire logic                   i_convert_strobe,
    input  wire logic [THERM_WIDTH-1:0] i_therm,
    input  wire logic                   i_msb_invert_n,
    input  wire logic                   i_lsb_invert_n,
    output logic      [WORD_WIDTH-1:0]  o_out_word,
    output logic                        o_word_update,
    output logic                        o_word_valid
);

    // strobe level last seen by the edge detector
    typedef enum logic {PHASE_LOW, PHASE_HIGH} strobe_phase_e;
    // whether a real comparator sample sits in the sample register
    typedef enum logic {FILL_EMPTY, FILL_HELD} fill_state_e;

    // strobe pin synchroniser, first stage read only by the second
    logic                        strobe_meta_reg;
    logic                        strobe_sync_reg;
    wire logic                   strobe_meta_next;
    wire logic                   strobe_sync_next;

    // edge detector state
    strobe_phase_e               phase_reg;
    strobe_phase_e               phase_next;
    wire logic                   strobe_rise;

    // per-line synchronisers gathered into words
    wire logic [THERM_WIDTH-1:0] therm_synced;
    wire logic [1:0]             ctrl_pins;
    wire logic [1:0]             ctrl_synced;
    wire logic                   msb_ctrl;
    wire logic                   lsb_ctrl;

    // pipeline state
    logic [THERM_WIDTH-1:0]      sample_reg;
    fill_state_e                 fill_reg;
    logic                        word_msb_reg;
    logic [LSB_FIELD_HI:0]       word_lsb_reg;
    logic                        word_update_reg;
    logic                        word_valid_reg;

    // next values of the pipeline state
    wire logic [THERM_WIDTH-1:0] sample_next;
    fill_state_e                 fill_next;
    wire logic                   sample_held;
    wire logic [WORD_WIDTH-1:0]  encoded_word;
    wire logic                   word_msb_next;
    wire logic [LSB_FIELD_HI:0]  word_lsb_next;
    wire logic                   word_update_next;
    wire logic                   word_valid_next;

    assign strobe_meta_next = i_convert_strobe;
    assign strobe_sync_next = strobe_meta_reg;

    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            strobe_meta_reg <= 1'h0;
        end
        else
        begin
            strobe_meta_reg <= strobe_meta_next;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            strobe_sync_reg <= 1'h0;
        end
        else
        begin
            strobe_sync_reg <= strobe_sync_next;
        end
    end

    // a rise is a low phase meeting a high synchronised strobe
    always_comb
    begin
        phase_next = phase_reg;
        unique case (phase_reg)
            PHASE_LOW:
            begin
                if (strobe_sync_reg)
                begin
                    phase_next = PHASE_HIGH;
                end
            end
            PHASE_HIGH:
            begin
                if (!strobe_sync_reg)
                begin
                    phase_next = PHASE_LOW;
                end
            end
        endcase
    end

    // resets low, so a strobe held high through reset reads as a rise
    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            phase_reg <= PHASE_LOW;
        end
        else
        begin
            phase_reg <= phase_next;
        end
    end

    assign strobe_rise = (phase_reg == PHASE_LOW) && strobe_sync_reg;

    // one two-stage synchroniser per comparator line
    for (genvar g = 0; g < THERM_WIDTH; g++)
    begin : g_therm_sync
        logic meta_reg;
        logic sync_reg;

        always_ff @(posedge i_clock or negedge i_rst_b)
        begin
            if (!i_rst_b)
            begin
                meta_reg <= THERM_RESET[g];
                sync_reg <= THERM_RESET[g];
            end
            else
            begin
                meta_reg <= i_therm[g];
                sync_reg <= meta_reg;
            end
        end

        assign therm_synced[g] = sync_reg;
    end

    // controls kept as a pair, msb control in bit 1
    assign ctrl_pins = {i_msb_invert_n, i_lsb_invert_n};

    for (genvar g = 0; g < $bits(ctrl_pins); g++)
    begin : g_ctrl_sync
        logic meta_reg;
        logic sync_reg;

        always_ff @(posedge i_clock or negedge i_rst_b)
        begin
            if (!i_rst_b)
            begin
                meta_reg <= CTRL_RESET;
                sync_reg <= CTRL_RESET;
            end
            else
            begin
                meta_reg <= ctrl_pins[g];
                sync_reg <= meta_reg;
            end
        end

        assign ctrl_synced[g] = sync_reg;
    end

    assign msb_ctrl = ctrl_synced[1];
    assign lsb_ctrl = ctrl_synced[0];

    // encodes the sample held from the previous strobe
    thermometer_encoder u_encoder (
        .i_therm        (sample_reg),
        .i_msb_invert_n (msb_ctrl),
        .i_lsb_invert_n (lsb_ctrl),
        .o_code         (encoded_word)
    );

    // first strobe only primes the sample; its word encodes the reset pattern
    always_comb
    begin
        fill_next = fill_reg;
        unique case (fill_reg)
            FILL_EMPTY:
            begin
                if (strobe_rise)
                begin
                    fill_next = FILL_HELD;
                end
            end
            FILL_HELD:
            begin
                fill_next = FILL_HELD;
            end
        endcase
    end

    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            fill_reg <= FILL_EMPTY;
        end
        else
        begin
            fill_reg <= fill_next;
        end
    end

    assign sample_next      = therm_synced;
    assign sample_held      = (fill_reg == FILL_HELD);
    assign word_msb_next    = encoded_word[MSB_POS];
    assign word_lsb_next    = encoded_word[LSB_FIELD_HI:0];
    assign word_update_next = strobe_rise;
    assign word_valid_next  = sample_held;

    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            sample_reg <= THERM_RESET;
        end
        else if (strobe_rise)
        begin
            sample_reg <= sample_next;
        end
    end

    // output fields move only on a strobe step, never in between
    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            word_msb_reg <= WORD_RESET[MSB_POS];
        end
        else if (strobe_rise)
        begin
            word_msb_reg <= word_msb_next;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            word_lsb_reg <= WORD_RESET[LSB_FIELD_HI:0];
        end
        else if (strobe_rise)
        begin
            word_lsb_reg <= word_lsb_next;
        end
    end

    // one-cycle pulse beside a fresh word
    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            word_update_reg <= 1'h0;
        end
        else
        begin
            word_update_reg <= word_update_next;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            word_valid_reg <= 1'h0;
        end
        else if (strobe_rise)
        begin
            word_valid_reg <= word_valid_next;
        end
    end

    assign o_out_word    = {word_msb_reg, word_lsb_reg};
    assign o_word_update = word_update_reg;
    assign o_word_valid  = word_valid_reg;

endmodule : flash_adc_encoder_output

`default_nettype wire

// File: flash_adc_encoder_output_chk.sv
`timescale 1ns/1ps
`default_nettype none
module flash_adc_encoder_output_chk
    import adc_encoder_pkg::*;
(
    input wire logic                  i_clock,
    input wire logic                  i_rst_b,
    input wire logic                  i_convert_strobe,
    input wire logic                  i_msb_invert_n,
    input wire logic [WORD_WIDTH-1:0] o_out_word,
    input wire logic                  o_word_update,
    input wire logic                  o_word_valid
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_b);
    AST_HOLD: assert property (!o_word_update |-> $stable(o_out_word)) else $error("hold");
    AST_PULSE: assert property (o_word_update |=> !o_word_update [*3]) else $error("pulse");
    AST_LAT: assert property ($rose(i_convert_strobe) |-> ##3 o_word_update) else $error("lat");
    AST_CAUSE: assert property (o_word_update |-> $past(i_convert_strobe, 3)) else $error("cause");
    AST_QUIET: assert property (!i_convert_strobe [*4] |=> !o_word_update) else $error("quiet");
    AST_KEEP: assert property (o_word_valid |=> o_word_valid) else $error("keep");
    AST_FIRST: assert property ($rose(o_word_valid) |-> $rose(o_word_update)) else $error("first");
    AST_RST: assert property (disable iff (1'b0) !i_rst_b && !$past(i_rst_b) |->
        o_out_word == WORD_RESET && !o_word_valid) else $error("rst");
    COV_UPD: cover property (o_word_update);
    COV_VALID: cover property ($rose(o_word_valid));
    COV_MSB: cover property (o_word_update && !i_msb_invert_n);
endmodule : flash_adc_encoder_output_chk
bind flash_adc_encoder_output flash_adc_encoder_output_chk chk (.i_clock(i_clock), .i_rst_b(i_rst_b),
    .i_convert_strobe(i_convert_strobe), .i_msb_invert_n(i_msb_invert_n), .o_out_word(o_out_word),
    .o_word_update(o_word_update), .o_word_valid(o_word_valid));
`default_nettype wire

// File: sample_capture_model.sv
`timescale 1ns/1ps
`default_nettype none
module sample_capture_model
    import adc_encoder_pkg::*;
(
    input  wire logic                  i_clock,
    input  wire logic [WORD_WIDTH-1:0] i_word,
    input  wire logic                  i_update,
    output logic      [WORD_WIDTH-1:0] o_word
);
    always @(posedge i_clock)
        if (i_update)
            o_word <= i_word;
endmodule : sample_capture_model
`default_nettype wire

// File: flash_adc_encoder_output_tb.sv
`timescale 1ns/1ps
`default_nettype none
module flash_adc_encoder_output_tb
    import adc_encoder_pkg::*;
;
    logic                   i_clock = 1'b0, i_rst_b = 1'b0, i_convert_strobe = 1'b0;
    logic                   i_msb_invert_n = 1'b1, i_lsb_invert_n = 1'b1;
    logic [THERM_WIDTH-1:0] i_therm = '0, prev = '0;
    logic [WORD_WIDTH-1:0]  o_out_word, cap_word;
    logic                   o_word_update, o_word_valid;
    int                     failures = 0, n_tests = 0;
    always #5 i_clock = ~i_clock;
    flash_adc_encoder_output dut (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_convert_strobe(i_convert_strobe),
        .i_therm(i_therm), .i_msb_invert_n(i_msb_invert_n), .i_lsb_invert_n(i_lsb_invert_n),
        .o_out_word(o_out_word), .o_word_update(o_word_update), .o_word_valid(o_word_valid));
    sample_capture_model far (.i_clock(i_clock), .i_word(o_out_word), .i_update(o_word_update), .o_word(cap_word));
    // true binary counts deasserted comparators; a low control complements its field
    function automatic logic [3:0] exp_word(input logic [14:0] t);
        logic [3:0] code;
        code = 4'($countones(~t));
        code[3] = i_msb_invert_n ? code[3] : ~code[3];
        code[2:0] = i_lsb_invert_n ? code[2:0] : ~code[2:0];
        return code;
    endfunction : exp_word
    task automatic chk(input logic [4:0] got, input logic [4:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic print_verdict;
        $display("comparisons %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : print_verdict
    initial
    begin
        repeat (8) @(posedge i_clock);
        i_rst_b <= 1'b1;
        void'($urandom(84528));
        for (int i = 0; i < 40; i++)
        begin
            i_msb_invert_n <= i < 4 ? i[1] : 1'($urandom);
            i_lsb_invert_n <= i < 4 ? i[0] : 1'($urandom);
            repeat (3) @(posedge i_clock);
            i_therm <= 15'h7fff >> (i < 4 ? 15 * i[0] : $urandom % 16);
            i_convert_strobe <= 1'b1;
            repeat (2) @(posedge i_clock);
            i_convert_strobe <= 1'b0;
            repeat (4) @(posedge i_clock);
            chk({o_word_valid, cap_word}, {1'(i > 0), exp_word(prev)});
            $display("test %0d done", i);
            prev = i_therm;
        end
        print_verdict();
    end
    initial
    begin
        #(40 * 9 * 10 * 4);
        failures++;
        print_verdict();
    end
endmodule : flash_adc_encoder_output_tb
`default_nettype wire
